/* File: sfx_cmd.sv */
// Serial flash instruction handler with its output byte FIFO
`timescale 1ns/1ps

// ============================================================
// Byte FIFO between reply generator and lane shifter
module sfx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             flush,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wp;
    logic [AW:0]                 rp;
  } sfx_fifo_st_t;

  sfx_fifo_st_t s;
  sfx_fifo_st_t next_s;

  // Full when pointers differ only in the wrap bit
  assign in_ready  = !((s.wp[AW] != s.rp[AW]) &&
                       (s.wp[AW-1:0] == s.rp[AW-1:0]));
  assign out_valid = s.wp != s.rp;
  assign out_data  = s.mem[s.rp[AW-1:0]];

  // Next state
  always_comb
  begin
    next_s = s;
    if (in_valid && in_ready)
    begin
      next_s.mem[s.wp[AW-1:0]] = in_data;
      next_s.wp = s.wp + 1'b1;
    end
    if (out_valid && out_ready)
      next_s.rp = s.rp + 1'b1;
    if (flush)
    begin
      next_s.wp = '0;
      next_s.rp = '0;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end
endmodule

// ============================================================
// Instruction handler
// Function
// - Dual data out: odd bits on lane one, even on zero, 7/6 first.
// - Dual address in: two bits per clock, odd on lane one, A23 first.
// - Quad data out: upper nibble first, lane three holds bits 7 and 3.
// - Quad address in: four bits per clock, top nibble first.
// - Quad I/O fast read: four don't-care clocks before data.
// - Wake instruction: three dummy bytes, then part code repeated.
// - Standard identity: maker, memory type, capacity bytes in order.
// - Dual/quad maker reads: lanes for address, maker/part alternate.
// - Security space: address bits 15..8 of 00/10/20/30 pick register.
// - Write enable instruction sets the write enable latch.
// - Program, erase and security writes need the latch set; status writes need it or volatile arming.
// - Volatile enable leaves latch clear, arms next status write only.
// - Write disable clears latch and cancels volatile arming.
// - Latch clears at reset and when an array write or timed status write completes.
// - Status read shifts selected byte MSB first, repeats until end.
// - Status reads are accepted even while busy.
// - Status write changes only bits 7..2 and 14..8.
// - Lock bits never return from one to zero.
// - Volatile write cannot clear high protect or lock bits.
// - While busy, every instruction but status read is ignored.
// - Status write needs 8 or 16 data bits; 8 clears three bits.
module sfx_cmd_top #(
  parameter int TW_CYCLES = sfx_pkg::TW_CYCLES
) (
  // Clock and reset
  input  wire logic              MCLK,
  input  wire logic              SYS_RST,
  // Serial pins
  input  wire logic              SPI_CS_N,
  input  wire logic              SPI_SCK,
  input  wire logic [3:0]        SPI_IO_IN,
  output sfx_pkg::sfx_pin_t      SPI_IO,
  // Array read port
  output logic [23:0]            ARRAY_ADDR,
  output logic                   ARRAY_SREG,
  output logic                   ARRAY_RD,
  input  wire logic [7:0]        ARRAY_RDATA,
  // Array write operations
  output sfx_pkg::sfx_wr_t       WR_CMD,
  input  wire logic              ARRAY_BUSY,
  input  wire logic              ARRAY_DONE,
  // Stored status copy
  input  wire logic [15:0]       NV_STATUS,
  output logic                   NV_WE,
  output logic [15:0]            NV_WDATA
);
  typedef struct packed {
    logic [2:0]          cs_sy;
    logic [2:0]          sck_sy;
    logic [3:0]          io_m;
    logic [3:0]          io_q;
    sfx_pkg::sfx_phase_t ph;
    sfx_pkg::sfx_dec_t   dec;
    logic [7:0]          op;
    logic [31:0]         sh;
    logic [5:0]          cnt;
    logic [15:0]         nbits;
    logic [23:0]         addr;
    logic                sreg_ok;
    logic                gen;
    logic [1:0]          gidx;
    logic [7:0]          obyte;
    logic [2:0]          ocnt;
    sfx_pkg::sfx_pin_t   pin;
    logic                write_enable_latch;
    logic                vol_armed;
    logic                st_busy;
    logic [23:0]         twc;
    logic [15:0]         wk;
    logic [15:0]         pend;
    logic                nv_we;
    sfx_pkg::sfx_wr_t    wr;
  } sfx_core_t;

  localparam logic [23:0] TW_LOAD = 24'(TW_CYCLES);
  localparam sfx_pkg::sfx_pin_t PIN_OFF = '{4'h0, 4'hf};

  sfx_core_t s;
  sfx_core_t next_s;

  logic       cs_fall;
  logic       cs_rise;
  logic       sck_rise;
  logic       sck_fall;
  logic       busy;
  logic       quad_lane_enable;
  logic [7:0] st_lo;
  logic [7:0] st_hi;
  logic       f_in_valid;
  logic       f_in_ready;
  logic [7:0] f_in_data;
  logic       f_out_valid;
  logic       f_out_ready;
  logic [7:0] f_out_data;
  logic       f_flush;
  logic [15:0] st_new;

  // Edges seen past the second synchroniser stage only
  assign cs_fall  = !s.cs_sy[1] && s.cs_sy[2];
  assign cs_rise  = s.cs_sy[1] && !s.cs_sy[2];
  assign sck_rise = s.sck_sy[1] && !s.sck_sy[2] && !s.cs_sy[1];
  assign sck_fall = !s.sck_sy[1] && s.sck_sy[2] && !s.cs_sy[1];
  assign f_flush  = cs_fall || cs_rise;

  // Live status bytes
  assign busy             = s.st_busy || ARRAY_BUSY;
  assign quad_lane_enable = s.wk[sfx_pkg::ST_QUAD_BIT];
  assign st_lo            = {s.wk[7:2], s.write_enable_latch, busy};
  assign st_hi            = s.wk[15:8];

  // Reply generator feeds the FIFO while the data phase lasts
  assign f_in_valid = s.gen && (s.ph == sfx_pkg::P_OUT);
  always_comb
  begin
    case (s.dec.src)
      sfx_pkg::S_ST_LO: f_in_data = st_lo;
      sfx_pkg::S_ST_HI: f_in_data = st_hi;
      sfx_pkg::S_PART:  f_in_data = sfx_pkg::PART_CODE;
      sfx_pkg::S_PAIR:
        f_in_data = s.gidx[0] ? sfx_pkg::PART_CODE : sfx_pkg::MAKER_CODE;
      sfx_pkg::S_STD:
        f_in_data = (s.gidx == 2'd0) ? sfx_pkg::MAKER_CODE :
                    (s.gidx == 2'd1) ? sfx_pkg::MEM_TYPE : sfx_pkg::CAPACITY;
      default:          f_in_data = ARRAY_RDATA;
    endcase
  end

  // Shifter takes a byte only at a byte boundary on a falling edge
  assign f_out_ready = sck_fall && (s.ph == sfx_pkg::P_OUT) &&
                       (s.ocnt == 3'd0);

  // Status write image: only writable bits move, lock bits only set
  always_comb
  begin
    logic [15:0] d;
    d = (s.nbits == sfx_pkg::BITS_LONG) ? {s.sh[7:0], s.sh[15:8]} :
        {s.wk[15:8] & ~sfx_pkg::ST_SHORT_CLR[15:8], s.sh[7:0]};
    st_new = (s.wk & ~sfx_pkg::ST_WR_MASK) |
             (d & sfx_pkg::ST_WR_MASK);
    st_new = st_new | (s.wk & sfx_pkg::ST_OTP_MASK);
    if (s.vol_armed)
      st_new = st_new | (s.wk & sfx_pkg::ST_PROT_HI);
  end

  sfx_fifo #(
    .WIDTH (8),
    .DEPTH (8)
  ) u_fifo (
    .clk       (MCLK),
    .rst       (SYS_RST),
    .flush     (f_flush),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // Next state of the whole handler
  always_comb
  begin
    sfx_pkg::sfx_dec_t dd;
    logic [31:0]       nsh;
    logic [23:0]       na;
    dd = sfx_pkg::sfx_decode(8'h00);
    nsh = s.sh;
    na = '0;
    next_s = s;
    next_s.cs_sy  = {s.cs_sy[1:0], SPI_CS_N};
    next_s.sck_sy = {s.sck_sy[1:0], SPI_SCK};
    next_s.io_m   = SPI_IO_IN;
    next_s.io_q   = s.io_m;
    next_s.nv_we  = 1'b0;
    next_s.wr.req = 1'b0;

    // Generator advances on each accepted byte
    if (f_in_valid && f_in_ready)
    begin
      next_s.gidx = s.gidx + 2'd1;
      if (s.dec.src == sfx_pkg::S_ARRAY)
        next_s.addr = s.addr + 24'd1;
      if (s.dec.src == sfx_pkg::S_STD && s.gidx == 2'd2)
        next_s.gen = 1'b0;
    end

    // Self-timed status write; the latch drops when it ends
    if (s.st_busy)
    begin
      next_s.twc = s.twc - 24'd1;
      if (s.twc <= 24'd1)
      begin
        next_s.st_busy = 1'b0;
        next_s.wk = s.pend;
        next_s.nv_we = 1'b1;
        next_s.write_enable_latch = 1'b0;
      end
    end
    if (ARRAY_DONE)
      next_s.write_enable_latch = 1'b0;

    // Serial clock rising edge: sample lanes
    if (sck_rise && s.ph != sfx_pkg::P_IDLE)
    begin
      next_s.nbits = s.nbits + 16'd1;
      next_s.cnt = s.cnt + 6'd1;
      case (s.dec.lin)
        3'd2:    nsh = {s.sh[29:0], s.io_q[1:0]};
        3'd4:    nsh = {s.sh[27:0], s.io_q};
        default: nsh = {s.sh[30:0], s.io_q[0]};
      endcase
      if (s.ph == sfx_pkg::P_CMD || s.ph == sfx_pkg::P_DIN)
        nsh = {s.sh[30:0], s.io_q[0]};
      na = s.dec.mode ? nsh[31:8] : nsh[23:0];
      case (s.ph)
        sfx_pkg::P_CMD:
        begin
          next_s.sh = nsh;
          if (s.cnt == 6'd7)
          begin
            dd = sfx_pkg::sfx_decode(nsh[7:0]);
            next_s.op = nsh[7:0];
            next_s.cnt = '0;
            next_s.dec = dd;
            if ((busy && nsh[7:0] != sfx_pkg::OP_RD_ST_LO &&
                 nsh[7:0] != sfx_pkg::OP_RD_ST_HI) ||
                (dd.quad && !quad_lane_enable))
              next_s.ph = sfx_pkg::P_IGN;
            else if (dd.aclk != 6'd0)
              next_s.ph = sfx_pkg::P_ADDR;
            else if (dd.kind == sfx_pkg::K_OUT)
            begin
              next_s.ph = sfx_pkg::P_OUT;
              next_s.gen = 1'b1;
            end
            else
              next_s.ph = sfx_pkg::P_DIN;
          end
        end
        sfx_pkg::P_ADDR:
        begin
          next_s.sh = nsh;
          if (s.cnt == s.dec.aclk - 6'd1)
          begin
            next_s.addr = na;
            next_s.cnt = '0;
            next_s.sreg_ok = (na & sfx_pkg::SREG_ZERO) == 24'h000000;
            if (s.dec.kind != sfx_pkg::K_OUT)
              next_s.ph = sfx_pkg::P_DIN;
            else if (s.dec.sreg &&
                     (na & sfx_pkg::SREG_ZERO) != 24'h000000)
              next_s.ph = sfx_pkg::P_IGN;
            else if (s.dec.dclk != 4'd0)
              next_s.ph = sfx_pkg::P_DUMMY;
            else
            begin
              next_s.ph = sfx_pkg::P_OUT;
              next_s.gen = 1'b1;
            end
          end
        end
        sfx_pkg::P_DUMMY:
        begin
          // Lanes stay released through the don't-care clocks
          if (s.cnt == {2'b00, s.dec.dclk} - 6'd1)
          begin
            next_s.ph = sfx_pkg::P_OUT;
            next_s.gen = 1'b1;
          end
        end
        sfx_pkg::P_DIN:
          next_s.sh = nsh;
        default:
          next_s.sh = s.sh;
      endcase
    end

    // Serial clock falling edge: drive the next lane group
    if (sck_fall && s.ph == sfx_pkg::P_OUT)
    begin
      if (s.ocnt == 3'd0)
      begin
        if (f_out_valid)
        begin
          next_s.pin = sfx_pkg::sfx_drive(f_out_data, s.dec.lout);
          next_s.obyte = f_out_data << s.dec.lout;
          next_s.ocnt = 3'd7 >> s.dec.lout[2:1];
        end
        else
          next_s.pin = PIN_OFF;
      end
      else
      begin
        next_s.pin = sfx_pkg::sfx_drive(s.obyte, s.dec.lout);
        next_s.obyte = s.obyte << s.dec.lout;
        next_s.ocnt = s.ocnt - 3'd1;
      end
    end

    // Chip select rises: execute framed instructions
    if (cs_rise)
    begin
      next_s.ph = sfx_pkg::P_IDLE;
      next_s.pin = PIN_OFF;
      next_s.gen = 1'b0;
      case (s.ph == sfx_pkg::P_IGN ? sfx_pkg::K_IGN : s.dec.kind)
        sfx_pkg::K_WREN:
          if (s.nbits == sfx_pkg::BITS_OPCODE)
            next_s.write_enable_latch = 1'b1;
        sfx_pkg::K_VWREN:
          if (s.nbits == sfx_pkg::BITS_OPCODE)
            next_s.vol_armed = 1'b1;
        sfx_pkg::K_WRDI:
          if (s.nbits == sfx_pkg::BITS_OPCODE)
          begin
            next_s.write_enable_latch = 1'b0;
            next_s.vol_armed = 1'b0;
          end
        sfx_pkg::K_WRSTAT:
          if (s.nbits == sfx_pkg::BITS_SHORT ||
              s.nbits == sfx_pkg::BITS_LONG)
          begin
            next_s.vol_armed = 1'b0;
            if (s.vol_armed)
              next_s.wk = st_new;
            else if (s.write_enable_latch)
            begin
              next_s.pend = st_new;
              next_s.st_busy = 1'b1;
              next_s.twc = TW_LOAD;
            end
          end
        sfx_pkg::K_WRITE:
          if (s.write_enable_latch && s.nbits[2:0] == 3'd0 &&
              s.ph == sfx_pkg::P_DIN && (!s.dec.sreg || s.sreg_ok))
            next_s.wr = '{1'b1, s.op, s.addr};
        default:
          next_s.wr.req = 1'b0;
      endcase
    end

    // Chip select falls: start a new frame
    if (cs_fall)
    begin
      next_s.ph = sfx_pkg::P_CMD;
      next_s.cnt = '0;
      next_s.nbits = '0;
      next_s.sh = '0;
      next_s.gen = 1'b0;
      next_s.gidx = '0;
      next_s.ocnt = '0;
      next_s.pin = PIN_OFF;
      next_s.dec = sfx_pkg::sfx_decode(8'h00);
    end
  end

  // State register; working status reloads from the stored copy
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      s <= '0;
      s.cs_sy <= 3'b111;
      s.pin <= PIN_OFF;
      s.wk <= NV_STATUS & sfx_pkg::ST_WR_MASK;
    end
    else
      s <= next_s;
  end

  // Outputs
  assign SPI_IO     = s.pin;
  assign ARRAY_ADDR = s.addr;
  assign ARRAY_SREG = s.dec.sreg;
  assign ARRAY_RD   = f_in_valid && f_in_ready &&
                      (s.dec.src == sfx_pkg::S_ARRAY);
  assign WR_CMD     = s.wr;
  assign NV_WE      = s.nv_we;
  assign NV_WDATA   = s.wk;
endmodule

/* File: sfx_pkg.sv */
// Constants, types and helpers for the serial flash command block
package sfx_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_NS    = 5;
  localparam int TW_NS     = 1000000; // Status write cycle, plain default
  localparam int TW_CYCLES = (TW_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================
  // Instruction codes
  localparam logic [7:0] OP_WR_EN = 8'h06, OP_VOL_EN = 8'h50;
  localparam logic [7:0] OP_WR_DIS = 8'h04, OP_WR_STAT = 8'h01;
  localparam logic [7:0] OP_RD_ST_LO = 8'h05, OP_RD_ST_HI = 8'h35;
  localparam logic [7:0] OP_PROG = 8'h02, OP_QPROG = 8'h32;
  localparam logic [7:0] OP_ER_4K = 8'h20, OP_ER_32K = 8'h52;
  localparam logic [7:0] OP_ER_64K = 8'hd8, OP_ER_ALL = 8'hc7;
  localparam logic [7:0] OP_ER_ALL2 = 8'h60, OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0b, OP_FAST_X2 = 8'h3b;
  localparam logic [7:0] OP_FAST_X4 = 8'h6b, OP_IO_X2 = 8'hbb;
  localparam logic [7:0] OP_IO_X4 = 8'heb, OP_WORD_X4 = 8'he7;
  localparam logic [7:0] OP_OCT_X4 = 8'he3, OP_WAKE_CODE = 8'hab;
  localparam logic [7:0] OP_MAKER = 8'h90, OP_MAKER_X2 = 8'h92;
  localparam logic [7:0] OP_MAKER_X4 = 8'h94, OP_STD_IDENT = 8'h9f;
  localparam logic [7:0] OP_SREG_ER = 8'h44, OP_SREG_PG = 8'h42;
  localparam logic [7:0] OP_SREG_RD = 8'h48;

  // ==========================================================
  // Status layout and security register address decode
  localparam logic [15:0] ST_WR_MASK   = 16'h7ffc; // 14..8 and 7..2
  localparam logic [15:0] ST_OTP_MASK  = 16'h3c00; // Lock bits
  localparam logic [15:0] ST_PROT_HI   = 16'h0100;
  localparam logic [15:0] ST_SHORT_CLR = 16'h4300; // Compl, quad, prot hi
  localparam int          ST_QUAD_BIT  = 9;
  localparam logic [23:0] SREG_ZERO    = 24'hffcf00;
  localparam logic [15:0] BITS_SHORT   = 16'h0010;
  localparam logic [15:0] BITS_LONG    = 16'h0018;
  localparam logic [15:0] BITS_OPCODE  = 16'h0008;

  // Identity values are arbitrary
  localparam logic [7:0] MAKER_CODE = 8'h5a;
  localparam logic [7:0] PART_CODE  = 8'h3c;
  localparam logic [7:0] MEM_TYPE   = 8'h41;
  localparam logic [7:0] CAPACITY   = 8'h27;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {K_IGN, K_OUT, K_WREN, K_VWREN, K_WRDI,
                            K_WRSTAT, K_WRITE} sfx_kind_t;
  typedef enum logic [2:0] {S_ST_LO, S_ST_HI, S_PART, S_PAIR, S_STD,
                            S_ARRAY} sfx_src_t;
  typedef enum logic [2:0] {P_IDLE, P_CMD, P_ADDR, P_DUMMY, P_OUT,
                            P_DIN, P_IGN} sfx_phase_t;
  typedef struct packed {
    sfx_kind_t  kind;
    sfx_src_t   src;
    logic [2:0] lin;   // Lanes for address
    logic [2:0] lout;  // Lanes for data out
    logic [5:0] aclk;  // Address plus mode clocks
    logic [3:0] dclk;  // Dummy clocks
    logic       mode;  // Mode byte follows address
    logic       quad;  // Needs quad lane enable
    logic       sreg;  // Security register space
  } sfx_dec_t;
  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe_n;
  } sfx_pin_t;
  typedef struct packed {
    logic        req;
    logic [7:0]  code;
    logic [23:0] addr;
  } sfx_wr_t;

  // ==========================================================
  // Opcode decode table
  function automatic sfx_dec_t sfx_decode(input logic [7:0] op);
    sfx_dec_t d;
    d = '{K_IGN, S_ARRAY, 3'd1, 3'd1, 6'd0, 4'd0, 1'b0, 1'b0, 1'b0};
    case (op)
      OP_WR_EN:     d.kind = K_WREN;
      OP_VOL_EN:    d.kind = K_VWREN;
      OP_WR_DIS:    d.kind = K_WRDI;
      OP_WR_STAT:   d.kind = K_WRSTAT;
      // Packed image: last three bits are mode, quad and security flags
      OP_RD_ST_LO:  d = {K_OUT, S_ST_LO, 3'd1, 3'd1, 6'd0, 4'd0, 3'b000};
      OP_RD_ST_HI:  d = {K_OUT, S_ST_HI, 3'd1, 3'd1, 6'd0, 4'd0, 3'b000};
      OP_PROG, OP_ER_4K, OP_ER_32K, OP_ER_64K:
        d = {K_WRITE, S_ARRAY, 3'd1, 3'd1, 6'd24, 4'd0, 3'b000};
      OP_QPROG:     d = {K_WRITE, S_ARRAY, 3'd1, 3'd1, 6'd24, 4'd0, 3'b010};
      OP_ER_ALL, OP_ER_ALL2:
        d.kind = K_WRITE;
      OP_SREG_ER, OP_SREG_PG:
        d = {K_WRITE, S_ARRAY, 3'd1, 3'd1, 6'd24, 4'd0, 3'b001};
      OP_SREG_RD:   d = {K_OUT, S_ARRAY, 3'd1, 3'd1, 6'd24, 4'd8, 3'b001};
      OP_READ:      d = {K_OUT, S_ARRAY, 3'd1, 3'd1, 6'd24, 4'd0, 3'b000};
      OP_FAST:      d = {K_OUT, S_ARRAY, 3'd1, 3'd1, 6'd24, 4'd8, 3'b000};
      OP_FAST_X2:   d = {K_OUT, S_ARRAY, 3'd1, 3'd2, 6'd24, 4'd8, 3'b000};
      OP_FAST_X4:   d = {K_OUT, S_ARRAY, 3'd1, 3'd4, 6'd24, 4'd8, 3'b010};
      OP_IO_X2:     d = {K_OUT, S_ARRAY, 3'd2, 3'd2, 6'd16, 4'd0, 3'b100};
      OP_IO_X4:     d = {K_OUT, S_ARRAY, 3'd4, 3'd4, 6'd8, 4'd4, 3'b110};
      OP_WORD_X4:   d = {K_OUT, S_ARRAY, 3'd4, 3'd4, 6'd8, 4'd2, 3'b110};
      OP_OCT_X4:    d = {K_OUT, S_ARRAY, 3'd4, 3'd4, 6'd8, 4'd0, 3'b110};
      OP_WAKE_CODE: d = {K_OUT, S_PART, 3'd1, 3'd1, 6'd24, 4'd0, 3'b000};
      OP_MAKER:     d = {K_OUT, S_PAIR, 3'd1, 3'd1, 6'd24, 4'd0, 3'b000};
      OP_MAKER_X2:  d = {K_OUT, S_PAIR, 3'd2, 3'd2, 6'd16, 4'd0, 3'b100};
      OP_MAKER_X4:  d = {K_OUT, S_PAIR, 3'd4, 3'd4, 6'd8, 4'd4, 3'b110};
      OP_STD_IDENT: d = {K_OUT, S_STD, 3'd1, 3'd1, 6'd0, 4'd0, 3'b000};
      default:      d.kind = K_IGN;
    endcase
    return d;
  endfunction

  // Top bits of a byte onto the lanes: one lane uses IO1, two use
  // IO1 (odd) and IO0 (even), four put the upper nibble on IO3..IO0
  function automatic sfx_pin_t sfx_drive(input logic [7:0] b,
                                         input logic [2:0] lanes);
    sfx_pin_t p;
    case (lanes)
      3'd2:    p = '{{2'b00, b[7:6]}, 4'b1100};
      3'd4:    p = '{b[7:4], 4'b0000};
      default: p = '{{2'b00, b[7], 1'b0}, 4'b1101};
    endcase
    return p;
  endfunction

endpackage

/* File: sfx_chk_sva.sv */
// Port checker for the flash command block
`timescale 1ns/1ps
// ============================================================
// Checker
module sfx_chk (
  // Clock and pins
  input wire logic        MCLK,
  input wire logic        SYS_RST,
  input wire logic        SPI_CS_N,
  input sfx_pkg::sfx_pin_t SPI_IO,
  // Write side
  input sfx_pkg::sfx_wr_t WR_CMD,
  input wire logic        ARRAY_BUSY,
  input wire logic        NV_WE,
  input wire logic [15:0] NV_WDATA
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // Select held high long enough for the lanes to be let go
  sequence idle_s;
    SPI_CS_N [*8];
  endsequence
  lane_free_a: assert property (idle_s |-> SPI_IO.oe_n == 4'hf)
    else $error("lane driven while idle");
  lane_set_a: assert property (SPI_IO.oe_n inside {4'hf, 4'hd, 4'hc, 4'h0})
    else $error("odd lane enables");
  rst_quiet_a: assert property (disable iff (1'b0) SYS_RST |=>
    SPI_IO.oe_n == 4'hf && !WR_CMD.req && !NV_WE) else $error("reset leak");
  req_pulse_a: assert property (WR_CMD.req |=> !WR_CMD.req)
    else $error("request too long");
  req_frame_a: assert property (WR_CMD.req |-> $past(SPI_CS_N, 3))
    else $error("request inside frame");
  code_hold_a: assert property (!WR_CMD.req |-> $stable(WR_CMD.code))
    else $error("code moved");
  req_idle_a: assert property (WR_CMD.req |-> !$past(ARRAY_BUSY))
    else $error("request while busy");
  nv_bits_a: assert property (NV_WE |-> (NV_WDATA & 16'h8003) == 0)
    else $error("fixed status bits stored");
endmodule

/* File: sfx_host.sv */
// Host model framing single-lane and multi-lane instructions
`timescale 1ns/1ps
// ============================================================
// Host
module sfx_host (
  // Clock and pins
  input  wire logic        mclk,
  input  sfx_pkg::sfx_pin_t io,
  output logic             cs_n = 1'b1,
  output logic             sck = 1'b0,
  output logic [3:0]       io_in
);
  logic       d0 = 1'b0;
  logic       hq = 1'b0;
  logic [3:0] hd = 4'h0;
  // Undriven lanes 3..1 show the inverse, lane 0 shows d0, so a stale value never matches;
  // while hq is set the host drives all four lanes itself
  assign io_in = hq ? hd :
                 ((io.o & ~io.oe_n) | ({~io.o[3:1], d0} & io.oe_n));
  // Eight MCLK per half keeps above the synchroniser minimum
  task automatic half();
    repeat (8) @(negedge mclk);
  endtask
  task automatic open();
    @(negedge mclk);
    cs_n = 1'b0;
    half();
  endtask
  task automatic close();
    half();
    cs_n = 1'b1;
    d0 = ~d0;
    repeat (12) @(negedge mclk);
  endtask
  // One byte out on lane zero, one byte in from lane one, MSB first
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      d0 = tx[i];
      half();
      sck = 1'b1;
      rx[i] = io.o[1];
      half();
      sck = 1'b0;
    end
  endtask
  // One clock with a nibble on the lanes, or lanes let go; returns
  // what the block shows on its lanes at the rising edge
  task automatic nib(input logic [3:0] tx, input logic drv,
                     output logic [3:0] rx);
    hq = drv;
    hd = tx;
    half();
    sck = 1'b1;
    rx = io.o;
    half();
    sck = 1'b0;
  endtask
  // Whole frame of n bytes, byte boundary kept
  task automatic send(input logic [31:0] b, input int n);
    logic [7:0] r;
    open();
    for (int i = n - 1; i >= 0; i--)
      xfer(b[8*i +: 8], r);
    close();
  endtask
endmodule

/* File: tb_top.sv */
// Self-checking bench for the flash command block
`timescale 1ns/1ps
// ============================================================
// Bench
module tb_top;
  logic mclk = 1'b0, rst = 1'b1, busy = 1'b0, done = 1'b0;
  logic cs_n, sck, nv_we;
  logic [3:0] io_in;
  logic [23:0] addr;
  logic [15:0] nv_wdata;
  sfx_pkg::sfx_pin_t io;
  sfx_pkg::sfx_wr_t wr;
  int errors = 0, total_checks = 0, cyc = 0, reqs = 0, nvs = 0;
  sfx_cmd_top #(.TW_CYCLES(20)) sfx_cmd_top_inst (.MCLK(mclk),
    .SYS_RST(rst), .SPI_CS_N(cs_n), .SPI_SCK(sck), .SPI_IO_IN(io_in),
    .SPI_IO(io), .ARRAY_ADDR(addr), .ARRAY_SREG(), .ARRAY_RD(),
    .ARRAY_RDATA(addr[7:0] ^ 8'h5a), .WR_CMD(wr), .ARRAY_BUSY(busy),
    .ARRAY_DONE(done), .NV_STATUS(16'h3c9c), .NV_WE(nv_we),
    .NV_WDATA(nv_wdata));
  sfx_host sfx_host_inst (.mclk(mclk), .io(io), .cs_n(cs_n), .sck(sck),
    .io_in(io_in));
  initial forever #2.5 mclk = ~mclk;
  task automatic close_out();
    if (errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Count pulses; a hang counts as a mismatch
  always @(negedge mclk)
  begin
    cyc++;
    if (wr.req === 1'b1) reqs++;
    if (nv_we === 1'b1) nvs++;
    if (cyc == 30000)
    begin
      errors++;
      close_out();
    end
  end
  // Two repeats of a status byte in one frame
  task automatic rd(input logic [7:0] op, input logic [7:0] exp);
    logic [7:0] r;
    sfx_host_inst.open();
    sfx_host_inst.xfer(op, r);
    sfx_host_inst.xfer(8'h00, r);
    chk({8'h00, r}, {8'h00, exp});
    sfx_host_inst.xfer(8'h00, r);
    chk({8'h00, r}, {8'h00, exp});
    sfx_host_inst.close();
  endtask
  task automatic t_latch();
    rd(8'h05, 8'h9c);
    rd(8'h35, 8'h3c);
    sfx_host_inst.send(32'h06, 1);
    rd(8'h05, 8'h9e);
    sfx_host_inst.send(32'h04, 1);
    rd(8'h05, 8'h9c);
  endtask
  task automatic t_ident();
    logic [7:0] r;
    sfx_host_inst.open();
    sfx_host_inst.xfer(8'h9f, r);
    sfx_host_inst.xfer(8'h00, r);
    chk({8'h00, r}, {8'h00, sfx_pkg::MAKER_CODE});
    sfx_host_inst.xfer(8'h00, r);
    chk({8'h00, r}, {8'h00, sfx_pkg::MEM_TYPE});
    sfx_host_inst.xfer(8'h00, r);
    chk({8'h00, r}, {8'h00, sfx_pkg::CAPACITY});
    sfx_host_inst.close();
  endtask
  // Erase refused without latch, taken with it, then busy and done
  task automatic t_write();
    for (int k = 0; k < 2; k++)
    begin
      if (k == 1) sfx_host_inst.send(32'h06, 1);
      sfx_host_inst.send(32'h20123456, 4);
      chk(16'(reqs), 16'(k));
    end
    chk({8'h00, wr.code}, 16'h0020);
    busy = 1'b1;
    sfx_host_inst.send(32'h04, 1);
    rd(8'h05, 8'h9f);
    done = 1'b1;
    busy = 1'b0;
    @(negedge mclk) done = 1'b0;
    rd(8'h05, 8'h9c);
  endtask
  task automatic t_status();
    sfx_host_inst.send(32'h50, 1);
    sfx_host_inst.send(32'h0100, 2);
    rd(8'h35, 8'h3c);
    rd(8'h05, 8'h00);
    sfx_host_inst.send(32'h06, 1);
    sfx_host_inst.send(32'h0100ff, 3);
    repeat (40) @(negedge mclk);
    chk(16'(nvs), 16'h0001);
    chk(nv_wdata, 16'h7f00);
    rd(8'h05, 8'h00);
    rd(8'h35, 8'h7f);
    sfx_host_inst.send(32'h50, 1);
    sfx_host_inst.send(32'h010002, 3);
    rd(8'h35, 8'h3f);
  endtask
  // Opcode, then address 000010h and zero mode bits on n lanes, d
  // don't-care clocks, then two bytes back on the same lanes
  task automatic mrd(input logic [7:0] op, input int n, input int d,
                     output logic [15:0] got);
    logic [7:0]  r;
    logic [3:0]  q;
    logic [31:0] a;
    a = 32'h00001000;
    got = '0;
    sfx_host_inst.open();
    sfx_host_inst.xfer(op, r);
    for (int i = 0; i < 32 / n; i++)
    begin
      sfx_host_inst.nib(4'(a[31:28] >> (4 - n)), 1'b1, q);
      a = a << n;
    end
    repeat (d) sfx_host_inst.nib(4'h0, 1'b0, q);
    for (int i = 0; i < 16 / n; i++)
    begin
      sfx_host_inst.nib(4'h0, 1'b0, q);
      got = (n == 4) ? {got[11:0], q} : {got[13:0], q[1:0]};
    end
    sfx_host_inst.close();
  endtask
  // Multi-lane reads at an aligned address, quad lanes enabled by now
  task automatic t_multi();
    logic [15:0] g;
    mrd(8'he7, 4, 2, g);
    chk(g, 16'h4a4b);
    mrd(8'he3, 4, 0, g);
    chk(g, 16'h4a4b);
    mrd(8'heb, 4, 4, g);
    chk(g, 16'h4a4b);
    mrd(8'h92, 2, 0, g);
    chk(g, {sfx_pkg::MAKER_CODE, sfx_pkg::PART_CODE});
    mrd(8'h94, 4, 4, g);
    chk(g, {sfx_pkg::MAKER_CODE, sfx_pkg::PART_CODE});
  endtask
  initial
  begin
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    t_latch();
    t_ident();
    t_write();
    t_status();
    t_multi();
    close_out();
  end
endmodule
bind sfx_cmd_top sfx_chk sfx_chk_inst (.MCLK(MCLK), .SYS_RST(SYS_RST),
  .SPI_CS_N(SPI_CS_N), .SPI_IO(SPI_IO), .WR_CMD(WR_CMD),
  .ARRAY_BUSY(ARRAY_BUSY), .NV_WE(NV_WE), .NV_WDATA(NV_WDATA));
